//--- design/tics_regs.svh
`ifndef TICS_REGS_SVH
`define TICS_REGS_SVH
// register byte offsets
`define TICS_CTRL_OFS 5'h00
`define TICS_STAT_OFS 5'h04
`define TICS_CHA_OFS 5'h08
`define TICS_CHB_OFS 5'h0C
`define TICS_PHASE_OFS 5'h10
// control fields: three-level selects coded 00 low, 01 mid, 11 high
`define TICS_CTRL_TXSEL 1:0
`define TICS_CTRL_RXSEL 3:2
`define TICS_CTRL_PAR 5:4
`define TICS_CTRL_RATE 6
`define TICS_CTRL_W 7
// all three-level selects start at mid, rate select low
`define TICS_CTRL_RST 7'h15
// status fields
`define TICS_ST_PERR 1:0
`define TICS_ST_INVAL 2
`define TICS_ST_LOCK 3
`define TICS_ST_MULT 8:4
// pll multipliers for half-rate and full-rate reference
`define TICS_MULT_HALF 5'h14
`define TICS_MULT_FULL 5'h0A
// bus answers
`define TICS_RESP_OK 2'h0
`define TICS_RESP_ERR 2'h2
`endif

//--- design/tics_pkg.sv
package tics_pkg;
   typedef enum logic [1:0] {
      TICS_LOW = 2'h0,
      TICS_MID = 2'h1,
      TICS_HIGH = 2'h3
   } tics_level_e;

   typedef struct packed {
      logic oddParity;
      logic [1:0] txControlCode;
      logic [7:0] txDataByte;
   } tics_pins_s;

   typedef struct packed {
      logic specialCharSelect;
      tics_pins_s pins;
   } tics_char_s;

   // code 10 is treated like a floating input
   function automatic tics_level_e decodeLevel(input logic [1:0] code);
      case (code)
         2'h0: decodeLevel = TICS_LOW;
         2'h3: decodeLevel = TICS_HIGH;
         default: decodeLevel = TICS_MID;
      endcase
   endfunction : decodeLevel

   // odd parity: data plus parity bit must hold an odd count of ones
   function automatic logic parityBad(input tics_pins_s p);
      parityBad = ~(^{p.oddParity, p.txDataByte});
   endfunction : parityBad
endpackage : tics_pkg

//--- design/tics_sync.sv
`timescale 1ns/100ps
module tics_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_r;
   logic [W-1:0] s2_nxt;

   always_comb begin
      s1_nxt = d;
      s2_nxt = s1_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   assign q = s2_r;
endmodule : tics_sync

//--- design/tics_axil.sv
`timescale 1ns/100ps
`include "tics_regs.svh"
module tics_axil (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdData,
   input wire logic rdOk,
   output logic wrEn,
   output logic [4:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrOk
);
   logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic wrEn_r, wrEn_nxt, bvalid_r, bvalid_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [4:0] addr_r, addr_nxt;
   logic [31:0] data_r, data_nxt, rdata_r, rdata_nxt;
   logic [3:0] strb_r, strb_nxt;
   logic fire, arTake;

   always_comb begin
      awHave_nxt = awHave_r | (awvalid & awready_r);
      wHave_nxt = wHave_r | (wvalid & wready_r);
      addr_nxt = (awvalid & awready_r) ? awaddr : addr_r;
      data_nxt = (wvalid & wready_r) ? wdata : data_r;
      strb_nxt = (wvalid & wready_r) ? wstrb : strb_r;
      // address and data may arrive in either order
      fire = awHave_r & wHave_r & ~bvalid_r & ~wrEn_r;
      wrEn_nxt = fire;
      if (fire) begin
         awHave_nxt = 1'b0;
         wHave_nxt = 1'b0;
      end
      awready_nxt = ~awHave_nxt;
      wready_nxt = ~wHave_nxt;
      bvalid_nxt = bvalid_r ? ~bready : wrEn_r;
      bresp_nxt = wrEn_r ? (wrOk ? `TICS_RESP_OK : `TICS_RESP_ERR)
                         : bresp_r;
      arTake = arvalid & arready_r;
      rvalid_nxt = rvalid_r ? ~rready : arTake;
      rdata_nxt = arTake ? rdData : rdata_r;
      rresp_nxt = arTake ? (rdOk ? `TICS_RESP_OK : `TICS_RESP_ERR)
                         : rresp_r;
      arready_nxt = ~rvalid_nxt & ~arTake;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         wrEn_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `TICS_RESP_OK;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= `TICS_RESP_OK;
         addr_r <= 5'h00;
         data_r <= 32'h0000_0000;
         strb_r <= 4'h0;
         rdata_r <= 32'h0000_0000;
      end else begin
         awHave_r <= awHave_nxt;
         wHave_r <= wHave_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         wrEn_r <= wrEn_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         strb_r <= strb_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign wrEn = wrEn_r;
   assign wrAddr = addr_r;
   assign wrData = data_r;
   assign wrStrb = strb_r;
endmodule : tics_axil

//--- design/tics_tx_clock_select.sv
`timescale 1ns/100ps
`include "tics_regs.svh"
module tics_tx_clock_select (
   input wire logic clk,
   input wire logic rst,
   input wire logic referenceClockIn,
   input wire logic txChannelAInputClock,
   input wire logic txChannelBInputClock,
   input wire logic specialCharSelect,
   input wire logic txPhaseResetN,
   input wire tics_pkg::tics_pins_s txPinsA,
   input wire tics_pkg::tics_pins_s txPinsB,
   input wire logic [4:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [4:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic [1:0] capStrobe,
   output tics_pkg::tics_char_s txCharA,
   output tics_pkg::tics_char_s txCharB,
   output logic [4:0] txSymbolMult,
   output logic txSynthClockOut,
   output logic txSynthClockOutN,
   output logic rxOutputClockA,
   output logic rxOutputClockC
);
   localparam int SYNC_W = 27;

   logic [SYNC_W-1:0] syncQ;
   logic refS, clkAS, clkBS, scS, prnS, prnInvS;
   tics_pkg::tics_pins_s pinsAS, pinsBS;
   logic refP_r, clkAP_r, clkBP_r;
   logic refRise, refFall, refAny, clkARise, clkBRise, refCap;
   logic capA, capB, bypass, invalidMode, midTog;
   tics_pkg::tics_level_e txSel, rxSel, parSel;
   logic rate;

   logic [`TICS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [1:0] perr_r, perr_nxt, cap_r, cap_nxt, perrSet;
   tics_pkg::tics_char_s charA_r, charA_nxt, charB_r, charB_nxt;
   logic special_r, special_nxt;
   logic [7:0] sinceRef_r, sinceRef_nxt, phaseA_r, phaseA_nxt;
   logic [7:0] phaseB_r, phaseB_nxt;
   logic [7:0] sinceEdge_r, sinceEdge_nxt, halfLen_r, halfLen_nxt;
   logic synth_r, synth_nxt, synthN_r, rxA_r, rxC_r, rxNxt;
   logic [4:0] mult_r, mult_nxt;

   logic wrEn, wrOk, rdOk;
   logic [4:0] wrAddr;
   logic [31:0] wrData, rdData;
   logic [3:0] wrStrb;

   // pins and link clocks come from other domains
   tics_sync #(.W(SYNC_W)) uSync (
      .clk(clk),
      .rst(rst),
      .d({referenceClockIn, txChannelAInputClock, txChannelBInputClock,
          specialCharSelect, ~txPhaseResetN, txPinsA, txPinsB}),
      .q(syncQ)
   );
   assign {refS, clkAS, clkBS, scS, prnInvS, pinsAS, pinsBS} = syncQ;
   assign prnS = ~prnInvS; // sync reset then reads as held, not adjusting

   tics_axil uBus (
      .clk(clk),
      .rst(rst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rdData(rdData),
      .rdOk(rdOk),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrOk(wrOk)
   );

   // edge finding and source selection
   always_comb begin
      txSel = tics_pkg::decodeLevel(ctrl_r[`TICS_CTRL_TXSEL]);
      rxSel = tics_pkg::decodeLevel(ctrl_r[`TICS_CTRL_RXSEL]);
      parSel = tics_pkg::decodeLevel(ctrl_r[`TICS_CTRL_PAR]);
      rate = ctrl_r[`TICS_CTRL_RATE];
      refRise = refS & ~refP_r;
      refFall = ~refS & refP_r;
      refAny = refRise | refFall;
      clkARise = clkAS & ~clkAP_r;
      clkBRise = clkBS & ~clkBP_r;
      refCap = refRise | (rate & refFall);
      case (txSel)
         tics_pkg::TICS_LOW: begin
            capA = refCap;
            capB = refCap;
         end
         tics_pkg::TICS_MID: begin
            capA = clkARise;
            capB = clkBRise;
         end
         default: begin
            capA = clkARise;
            capB = clkARise;
         end
      endcase
      // flagged only; the capture path keeps running so nothing stalls
      invalidMode = rate & (txSel != tics_pkg::TICS_LOW);
      bypass = (txSel == tics_pkg::TICS_LOW) & ~rate;
   end

   // character capture and parity
   always_comb begin
      special_nxt = capA ? scS : special_r;
      charA_nxt = charA_r;
      charB_nxt = charB_r;
      if (capA) begin
         charA_nxt = {scS, pinsAS};
      end
      if (capB) begin
         charB_nxt = {special_nxt, pinsBS};
      end
      cap_nxt = {capB, capA};
      perrSet[0] = capA & tics_pkg::parityBad(pinsAS);
      perrSet[1] = capB & tics_pkg::parityBad(pinsBS);
      if (parSel == tics_pkg::TICS_LOW) begin
         perrSet = 2'h0;
      end
      perr_nxt = perr_r;
      if (wrEn && wrAddr == `TICS_STAT_OFS && wrStrb[0]) begin
         perr_nxt = perr_r & ~wrData[`TICS_ST_PERR];
      end
      // a new fault in the clearing cycle is kept
      perr_nxt = perr_nxt | perrSet;
   end

   // control register and bus decode
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wrEn && wrAddr == `TICS_CTRL_OFS && wrStrb[0]) begin
         ctrl_nxt = wrData[`TICS_CTRL_W-1:0];
      end
      case (wrAddr)
         `TICS_CTRL_OFS, `TICS_STAT_OFS, `TICS_CHA_OFS,
         `TICS_CHB_OFS, `TICS_PHASE_OFS: wrOk = 1'b1;
         default: wrOk = 1'b0;
      endcase
      rdOk = 1'b1;
      rdData = 32'h0000_0000;
      case (araddr)
         `TICS_CTRL_OFS: rdData[`TICS_CTRL_W-1:0] = ctrl_r;
         `TICS_STAT_OFS: begin
            rdData[`TICS_ST_PERR] = perr_r;
            rdData[`TICS_ST_INVAL] = invalidMode;
            rdData[`TICS_ST_LOCK] = prnS;
            rdData[`TICS_ST_MULT] = mult_r;
         end
         `TICS_CHA_OFS: rdData[11:0] = charA_r;
         `TICS_CHB_OFS: rdData[11:0] = charB_r;
         `TICS_PHASE_OFS: rdData[15:0] = {phaseB_r, phaseA_r};
         default: rdOk = 1'b0;
      endcase
   end

   // phase measure against the reference; counters saturate
   always_comb begin
      sinceRef_nxt = refRise ? 8'h00
         : (sinceRef_r == 8'hFF ? sinceRef_r : sinceRef_r + 8'h01);
      phaseA_nxt = phaseA_r;
      phaseB_nxt = phaseB_r;
      // bypassed buffer ignores the phase reset
      if (!prnS && !bypass) begin
         if (clkARise) begin
            phaseA_nxt = sinceRef_r;
         end
         if (clkBRise) begin
            phaseB_nxt = sinceRef_r;
         end
      end
   end

   // clock synthesis from reference edges; every sampled reference edge toggles the output,
   // so phase stays tied to the reference, delayed by the synchronizer and the synth_r register stage
   always_comb begin
      sinceEdge_nxt = refAny ? 8'h00
         : (sinceEdge_r == 8'hFF ? sinceEdge_r : sinceEdge_r + 8'h01);
      halfLen_nxt = refAny ? sinceEdge_r + 8'h01 : halfLen_r;
      midTog = rate & ~refAny & (halfLen_r > 8'h01)
         & (sinceEdge_r == {1'b0, halfLen_r[7:1]} - 8'h01);
      synth_nxt = synth_r ^ (refAny | midTog);
      rxNxt = (rxSel == tics_pkg::TICS_LOW) ? refS : synth_nxt;
      mult_nxt = rate ? `TICS_MULT_HALF : `TICS_MULT_FULL;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         refP_r <= 1'b0;
         clkAP_r <= 1'b0;
         clkBP_r <= 1'b0;
         ctrl_r <= `TICS_CTRL_RST;
         perr_r <= 2'h0;
         cap_r <= 2'h0;
         charA_r <= '0;
         charB_r <= '0;
         special_r <= 1'b0;
         sinceRef_r <= 8'h00;
         phaseA_r <= 8'h00;
         phaseB_r <= 8'h00;
         sinceEdge_r <= 8'h00;
         halfLen_r <= 8'h00;
         synth_r <= 1'b0;
         synthN_r <= 1'b1;
         rxA_r <= 1'b0;
         rxC_r <= 1'b0;
         mult_r <= `TICS_MULT_FULL;
      end else begin
         refP_r <= refS;
         clkAP_r <= clkAS;
         clkBP_r <= clkBS;
         ctrl_r <= ctrl_nxt;
         perr_r <= perr_nxt;
         cap_r <= cap_nxt;
         charA_r <= charA_nxt;
         charB_r <= charB_nxt;
         special_r <= special_nxt;
         sinceRef_r <= sinceRef_nxt;
         phaseA_r <= phaseA_nxt;
         phaseB_r <= phaseB_nxt;
         sinceEdge_r <= sinceEdge_nxt;
         halfLen_r <= halfLen_nxt;
         synth_r <= synth_nxt;
         synthN_r <= ~synth_nxt;
         rxA_r <= rxNxt;
         rxC_r <= rxNxt;
         mult_r <= mult_nxt;
      end
   end

   assign capStrobe = cap_r;
   assign txCharA = charA_r;
   assign txCharB = charB_r;
   assign txSymbolMult = mult_r;
   assign txSynthClockOut = synth_r;
   assign txSynthClockOutN = synthN_r;
   assign rxOutputClockA = rxA_r;
   assign rxOutputClockC = rxC_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence selMidARise;
      txSel == tics_pkg::TICS_MID && clkARise;
   endsequence

   sequence halfFall;
      rate && txSel == tics_pkg::TICS_LOW && refFall;
   endsequence

   lowRefCap_a: assert property (
      txSel == tics_pkg::TICS_LOW && refRise |=> cap_r == 2'h3)
      else $error("reference edge did not capture both channels");
   midOwnClk_a: assert property (
      txSel == tics_pkg::TICS_MID && clkBRise && !clkARise
      |=> cap_r == 2'h2 && charB_r.pins == $past(pinsBS))
      else $error("channel B missed its own clock");
   highAClk_a: assert property (
      txSel == tics_pkg::TICS_HIGH && clkARise |=> cap_r == 2'h3)
      else $error("channel A clock did not capture both channels");
   specialMid_a: assert property (
      selMidARise |=> txCharA.specialCharSelect == $past(scS))
      else $error("special select not taken on channel A clock");
   parityFlag_a: assert property (
      capA && parSel != tics_pkg::TICS_LOW
      && tics_pkg::parityBad(pinsAS) |=> perr_r[0] ##1 perr_r[0] || $past(wrEn))
      else $error("parity fault not flagged");
   halfRate_a: assert property (
      halfFall |=> cap_r[0] ##0 txCharA.pins == $past(pinsAS))
      else $error("falling reference edge missed at half rate");
   multSel_a: assert property (
      ##1 mult_r == ($past(rate) ? `TICS_MULT_HALF : `TICS_MULT_FULL))
      else $error("pll multiplier does not match rate select");
   rxFollow_a: assert property (
      rxSel == tics_pkg::TICS_LOW |=> rxA_r == $past(refS) && rxC_r == rxA_r)
      else $error("receive clocks do not follow the reference");
   synthPair_a: assert property (
      txSynthClockOutN == ~txSynthClockOut)
      else $error("synth clock pair not complementary");
   synthEdge_a: assert property (
      refAny |=> synth_r != $past(synth_r))
      else $error("synth clock missed a reference edge");
   phaseHold_a: assert property (
      prnS |=> $stable(phaseA_r) && $stable(phaseB_r))
      else $error("phase moved while phase reset high");
endmodule : tics_tx_clock_select

//--- bench/tics_host_model.sv
`timescale 1ns/100ps
module tics_host_model (
   input wire logic [1:0] srcSel,
   input wire tics_pkg::tics_pins_s reqA,
   input wire tics_pkg::tics_pins_s reqB,
   input wire logic reqSpecial,
   input wire logic reqAdjustN,
   output logic referenceClockIn,
   output logic txChannelAInputClock,
   output logic txChannelBInputClock,
   output logic specialCharSelect,
   output logic txPhaseResetN,
   output tics_pkg::tics_pins_s txPinsA,
   output tics_pkg::tics_pins_s txPinsB
);
   initial begin
      referenceClockIn = 1'b0;
      txChannelAInputClock = 1'b0;
      txChannelBInputClock = 1'b0;
      specialCharSelect = 1'b0;
      txPinsA = 11'h000;
      txPinsB = 11'h000;
   end
   // one period for all, so channel clocks stay coherent with the synth
   always #100 referenceClockIn = ~referenceClockIn;
   initial begin
      #50;
      forever #100 txChannelAInputClock = ~txChannelAInputClock;
   end
   initial begin
      #130;
      forever #100 txChannelBInputClock = ~txChannelBInputClock;
   end
   assign txPhaseResetN = reqAdjustN;
   // data moves on falling edges, half a period from the capturing rise
   always @(negedge referenceClockIn) begin
      if (srcSel == 2'h0) begin
         txPinsA <= reqA;
         txPinsB <= reqB;
         specialCharSelect <= reqSpecial;
      end
   end
   always @(negedge txChannelAInputClock) begin
      if (srcSel != 2'h0) begin
         txPinsA <= reqA;
         specialCharSelect <= reqSpecial;
         if (srcSel == 2'h3) txPinsB <= reqB;
      end
   end
   always @(negedge txChannelBInputClock) begin
      if (srcSel == 2'h1) txPinsB <= reqB;
   end
endmodule : tics_host_model

//--- bench/tics_tx_clock_select_tb.sv
`timescale 1ns/100ps
`include "tics_regs.svh"
module tics_tx_clock_select_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, capStrobe, rr;
   logic [31:0] rdata, rv;
   tics_pkg::tics_char_s txCharA, txCharB;
   logic [4:0] txSymbolMult;
   logic synP, synN, rxA, rxC, reference_clock_in, chA, chB, sc, phN;
   tics_pkg::tics_pins_s pinsA, pinsB;
   tics_pkg::tics_pins_s reqA = 11'h000, reqB = 11'h000;
   logic [1:0] srcSel = 2'h0;
   logic [1:0] lv;
   logic reqSpecial = 1'b0, reqAdjustN = 1'b1;
   int errTotal = 0, totalChecks = 0, nSyn, nRx, nCap;

   always #12.5 clk = ~clk;

   tics_host_model host_u (.srcSel(srcSel), .reqA(reqA), .reqB(reqB),
      .reqSpecial(reqSpecial), .reqAdjustN(reqAdjustN),
      .referenceClockIn(reference_clock_in), .txChannelAInputClock(chA),
      .txChannelBInputClock(chB), .specialCharSelect(sc),
      .txPhaseResetN(phN), .txPinsA(pinsA), .txPinsB(pinsB));

   tics_tx_clock_select dut_u (.clk(clk), .rst(rst),
      .referenceClockIn(reference_clock_in), .txChannelAInputClock(chA),
      .txChannelBInputClock(chB), .specialCharSelect(sc),
      .txPhaseResetN(phN), .txPinsA(pinsA), .txPinsB(pinsB),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .capStrobe(capStrobe),
      .txCharA(txCharA), .txCharB(txCharB), .txSymbolMult(txSymbolMult),
      .txSynthClockOut(synP), .txSynthClockOutN(synN),
      .rxOutputClockA(rxA), .rxOutputClockC(rxC));

   task final_report;
      if (errTotal == 0 && totalChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task hang(input int n);
      if (n >= 50) begin
         errTotal++;
         final_report();
      end
   endtask : hang

   task axWrite(input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      hang(n);
      rr = bresp;
      bready <= 1'b0;
   endtask : axWrite

   task axRead(input logic [4:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      hang(n);
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : axRead

   task waitStrobe(input int b);
      int n;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (capStrobe[b] === 1'b1) break;
      end
      hang(n);
   endtask : waitStrobe

   // settle time covers three full source periods after the request
   task sendChar(input tics_pkg::tics_pins_s a, input tics_pkg::tics_pins_s b,
                 input logic s, input logic both);
      reqA <= a;
      reqB <= b;
      reqSpecial <= s;
      repeat (24) @(posedge clk);
      waitStrobe(0);
      chk(32'(txCharA), 32'({s, a}));
      if (both) chk(32'(capStrobe), 32'h3);
      waitStrobe(1);
      chk(32'(txCharB), 32'({s, b}));
   endtask : sendChar

   task measure;
      logic ps, pr;
      nSyn = 0;
      nRx = 0;
      nCap = 0;
      ps = synP;
      pr = rxA;
      repeat (80) begin
         @(posedge clk);
         if (synP && !ps) nSyn++;
         if (rxA && !pr) nRx++;
         if (capStrobe[0]) nCap++;
         ps = synP;
         pr = rxA;
         chk(32'({synN, rxC}), 32'({~synP, rxA}));
      end
   endtask : measure

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(txSymbolMult), 32'(`TICS_MULT_FULL));
      chk(32'({synP, synN}), 32'h1);
      axRead(`TICS_CTRL_OFS);
      chk(32'(rr), 32'(`TICS_RESP_OK));
      chk(rv, 32'(`TICS_CTRL_RST));
      axRead(5'h14);
      chk(32'(rr), 32'(`TICS_RESP_ERR));
      chk(rv, 32'h0);
      axWrite(5'h18, 32'h1);
      chk(32'(rr), 32'(`TICS_RESP_ERR));
      for (int m = 0; m < 3; m++) begin
         lv = (m == 0) ? tics_pkg::TICS_LOW :
              (m == 1) ? tics_pkg::TICS_MID : tics_pkg::TICS_HIGH;
         axWrite(`TICS_CTRL_OFS, 32'h10 | 32'(lv));
         srcSel <= lv;
         sendChar({1'b1, 2'(m), 8'h5A}, {1'b1, 2'(3 - m), 8'hC3},
                  m[0], m != 1);
      end
      axWrite(`TICS_CTRL_OFS, 32'h10);
      srcSel <= 2'h0;
      // idle all-zero pins after reset already raised both flags
      axWrite(`TICS_STAT_OFS, 32'h3);
      sendChar(11'h000, 11'h4C3, 1'b0, 1'b1);
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[1:0]), 32'h1);
      sendChar(11'h45A, 11'h4C3, 1'b0, 1'b1);
      axWrite(`TICS_STAT_OFS, 32'h3);
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[1:0]), 32'h0);
      axWrite(`TICS_CTRL_OFS, 32'h00);
      sendChar(11'h000, 11'h000, 1'b0, 1'b1);
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[1:0]), 32'h0);
      axWrite(`TICS_CTRL_OFS, 32'h40);
      repeat (2) @(posedge clk);
      chk(32'(txSymbolMult), 32'(`TICS_MULT_HALF));
      measure();
      chk(32'(nSyn >= 19 && nSyn <= 21), 32'h1);
      chk(32'(nRx >= 9 && nRx <= 11), 32'h1);
      chk(32'(nCap >= 19 && nCap <= 21), 32'h1);
      axRead(`TICS_STAT_OFS);
      chk(32'({rv[8:4], rv[2]}), 32'({5'h14, 1'b0}));
      axWrite(`TICS_CTRL_OFS, 32'h00);
      measure();
      chk(32'(nSyn >= 9 && nSyn <= 11), 32'h1);
      chk(32'(nRx >= 9 && nRx <= 11), 32'h1);
      chk(32'(nCap >= 9 && nCap <= 11), 32'h1);
      // receive select mid: receive clocks track the synthesized clock
      axWrite(`TICS_CTRL_OFS, 32'h74);
      measure();
      chk(32'(nRx >= 19 && nRx <= 21), 32'h1);
      chk(32'(nSyn >= 19 && nSyn <= 21), 32'h1);
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[1:0]), 32'h3);
      // code 10 on the selector must not read as low, so half rate raises the invalid flag
      axWrite(`TICS_CTRL_OFS, 32'h42);
      srcSel <= 2'h1;
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[2]), 32'h1);
      axWrite(`TICS_CTRL_OFS, 32'h11);
      reqAdjustN <= 1'b0;
      repeat (40) @(posedge clk);
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[3]), 32'h0);
      axRead(`TICS_PHASE_OFS);
      chk(32'(rv[7:0] >= 1 && rv[7:0] <= 3), 32'h1);
      chk(32'(rv[15:8] >= 4 && rv[15:8] <= 6), 32'h1);
      reqAdjustN <= 1'b1;
      repeat (8) @(posedge clk);
      axRead(`TICS_STAT_OFS);
      chk(32'(rv[3]), 32'h1);
      final_report();
   end
endmodule : tics_tx_clock_select_tb
